// ### rtl/gtc_pkg.sv
/*
 * Package for the gated timer control block: register offsets, field
 * positions, reset values and prescale encodings.
 * Assumes a single 100 MHz clock domain and a plain strobe register port.
 */
package gtc_pkg;

	localparam int unsigned GTC_ADDR_W = 3;
	localparam int unsigned GTC_DATA_W = 8;

	// Register offsets
	localparam logic [2:0] GTC_OFF_TIMER_CONTROL = 3'h0;
	localparam logic [2:0] GTC_OFF_COUNT_LOW     = 3'h1;
	localparam logic [2:0] GTC_OFF_COUNT_HIGH    = 3'h2;
	localparam logic [2:0] GTC_OFF_GATE_SOURCE   = 3'h3;
	localparam logic [2:0] GTC_OFF_IRQ_STATUS    = 3'h4;
	localparam logic [2:0] GTC_OFF_IRQ_MASK      = 3'h5;

	// Field positions of timer_control
	localparam int unsigned GTC_BIT_TIMER_RUN     = 0;
	localparam int unsigned GTC_BIT_CLK_SOURCE    = 1;
	localparam int unsigned GTC_BIT_ASYNC_INPUT   = 2;
	localparam int unsigned GTC_BIT_LP_OSC_EN     = 3;
	localparam int unsigned GTC_BIT_PRESCALE_LO   = 4;
	localparam int unsigned GTC_BIT_GATE_ENABLE   = 6;
	localparam int unsigned GTC_BIT_GATE_INVERT   = 7;
	// Field positions of gate_source_config
	localparam int unsigned GTC_BIT_COMP_SYNC     = 0;
	localparam int unsigned GTC_BIT_GATE_SOURCE   = 1;
	// Field positions of irq status and mask
	localparam int unsigned GTC_BIT_OVERFLOW      = 0;

	// Reset values
	localparam logic [7:0] GTC_RST_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] GTC_RST_GATE_SOURCE   = 8'h02;
	localparam logic [7:0] GTC_RST_IRQ_MASK      = 8'h00;
	localparam logic [15:0] GTC_RST_COUNT        = 16'h0000;
	localparam logic [15:0] GTC_COUNT_MAX        = 16'hFFFF;

	// Prescale encodings
	typedef enum logic [1:0] {
		GTC_DIV1 = 2'b00,
		GTC_DIV2 = 2'b01,
		GTC_DIV4 = 2'b10,
		GTC_DIV8 = 2'b11
	} gtc_prescale_t;

	localparam logic [2:0] GTC_PRESCALE_MASK_DIV1 = 3'h0;
	localparam logic [2:0] GTC_PRESCALE_MASK_DIV2 = 3'h1;
	localparam logic [2:0] GTC_PRESCALE_MASK_DIV4 = 3'h3;
	localparam logic [2:0] GTC_PRESCALE_MASK_DIV8 = 3'h7;

	// Decoded view of timer_control
	typedef struct packed {
		logic          gate_polarity_invert;
		logic          gate_enable_bit;
		gtc_prescale_t prescale_select;
		logic          lowpower_osc_enable;
		logic          async_input_select;
		logic          clock_source_select;
		logic          timer_run;
	} gtc_ctrl_t;

	// Register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} gtc_req_t;

endpackage

// ### rtl/gtc_in_sync.sv
/*
 * Three-stage synchroniser with agreement filter for pin inputs.
 * Assumes the input is asynchronous to i_ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module gtc_in_sync
	import gtc_pkg::*;
#(
	parameter int unsigned WIDTH = 1
)
(
	input  wire logic             i_ref_clk,
	input  wire logic             i_reset_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	always_comb
	begin
		out_d = out_q;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s2_q[i] == s3_q[i])
			begin
				out_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end
		else
		begin
			s1_q  <= i_async;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
		end
	end

	assign o_sync = out_q;

endmodule
`default_nettype wire

// ### rtl/gtc_timer.sv
/*
 * Gated 16-bit timer/counter: control and gate source registers, prescaler,
 * counter bytes and a masked overflow interrupt.
 * Assumes one clock; instruction clock tick and oscillator mode come from the core.
 */
// Summary of operation
// - Timer counts only while the run bit (bit 0) is set.
// - Gate enable bit is ignored while the run bit is clear.
// - Prescale field 00/01/10/11 divides by 1/2/4/8.
// - With internal oscillator without clock output, bit 3 switches low-power oscillator.
// - In other oscillator configurations the low-power oscillator bit is ignored.
// - Besides the gate pin, only the second comparator output may serve as gate source.
// - Clock source bit 0 counts instruction clock, 1 counts external pin.
// - Async select bit passes external input unsynchronised to counter.
// - Pin or comparator gates counting only when gate enable is set.
// - Gate polarity bit inverts gate, counting while gate high.
`timescale 1ns/1ps
`default_nettype none
module gtc_timer
	import gtc_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_reset_n,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_instr_tick,
	input  wire logic       i_internal_oscillator_no_clock_output_pin,
	input  wire logic       i_external_count_pin,
	input  wire logic       i_lowpower_osc_clk,
	input  wire logic       i_gate_pin_n,
	input  wire logic       i_second_comparator_output,
	output logic            o_lowpower_osc_on,
	output logic            o_overflow_pulse,
	output logic            o_irq
);

	gtc_req_t  req;
	gtc_ctrl_t ctrl;

	logic [7:0]  ctrl_q;
	logic [7:0]  ctrl_d;
	logic [7:0]  gsrc_q;
	logic [7:0]  gsrc_d;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [2:0]  pre_q;
	logic [2:0]  pre_d;
	logic        ext_prev_q;
	logic        ext_prev_d;
	logic        stat_q;
	logic        stat_d;
	logic        mask_q;
	logic        mask_d;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        ovf_q;
	logic        ovf_d;

	logic [2:0]  pin_sync;
	logic        ext_sel;
	logic        ext_level;
	logic        src_tick;
	logic        gate_raw;
	logic        gate_ok;
	logic        pre_tick;
	logic        inc;
	logic        osc_on;
	logic        count_wr;

	assign req  = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
	assign ctrl = gtc_ctrl_t'(ctrl_q);

	function automatic logic [2:0] prescale_mask(input gtc_prescale_t sel);
		unique case (sel)
			GTC_DIV1: prescale_mask = GTC_PRESCALE_MASK_DIV1;
			GTC_DIV2: prescale_mask = GTC_PRESCALE_MASK_DIV2;
			GTC_DIV4: prescale_mask = GTC_PRESCALE_MASK_DIV4;
			GTC_DIV8: prescale_mask = GTC_PRESCALE_MASK_DIV8;
		endcase
	endfunction

	function automatic logic hit(input gtc_req_t r, input logic [2:0] off);
		hit = r.wr && (r.addr == off);
	endfunction

	// Pin inputs: external count, low-power oscillator, gate pin
	gtc_in_sync #(
		.WIDTH (3)
	) u_pin_sync (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_async   ({i_gate_pin_n, i_lowpower_osc_clk, i_external_count_pin}),
		.o_sync    (pin_sync)
	);

	always_comb
	begin
		// Oscillator enable honoured only with internal oscillator w/o clock out
		osc_on = i_internal_oscillator_no_clock_output_pin && ctrl.lowpower_osc_enable;

		// Low-power oscillator replaces the pin as external source when on
		if (osc_on)
		begin
			ext_sel = i_lowpower_osc_clk;
		end
		else
		begin
			ext_sel = i_external_count_pin;
		end

		// Async mode samples the raw input once; edge detection on one clock
		// still needs a register, so async trades metastability margin for latency
		if (ctrl.async_input_select)
		begin
			ext_level = ext_sel;
		end
		else if (osc_on)
		begin
			ext_level = pin_sync[1];
		end
		else
		begin
			ext_level = pin_sync[0];
		end

		if (ctrl.clock_source_select)
		begin
			src_tick = ext_level && !ext_prev_q;
		end
		else
		begin
			src_tick = i_instr_tick;
		end

		// Gate pin is active low; comparator only from the second one
		if (gsrc_q[GTC_BIT_GATE_SOURCE])
		begin
			gate_raw = !pin_sync[2];
		end
		else
		begin
			gate_raw = !i_second_comparator_output;
		end
		// Uninverted gate counts while low; invert counts while high
		if (ctrl.gate_polarity_invert)
		begin
			gate_raw = !gate_raw;
		end
		gate_ok = !ctrl.gate_enable_bit || gate_raw;
		ext_prev_d = ext_level;
	end

	// Prescaler and counter; a count write wins over an increment
	always_comb
	begin

		count_wr = hit(req, GTC_OFF_COUNT_LOW) || hit(req, GTC_OFF_COUNT_HIGH);
		pre_tick = ctrl.timer_run && gate_ok && src_tick;
		pre_d    = pre_q;
		inc      = 1'b0;
		if (count_wr)
		begin
			pre_d = '0;
		end
		else if (pre_tick)
		begin
			if ((pre_q & prescale_mask(ctrl.prescale_select)) ==
				prescale_mask(ctrl.prescale_select))
			begin
				pre_d = '0;
				inc   = 1'b1;
			end
			else
			begin
				pre_d = pre_q + 3'd1;
			end
		end

		count_d = count_q;
		ovf_d   = 1'b0;
		if (hit(req, GTC_OFF_COUNT_LOW))
		begin
			count_d[7:0] = req.wdata;
		end
		else if (hit(req, GTC_OFF_COUNT_HIGH))
		begin
			count_d[15:8] = req.wdata;
		end
		else if (inc)
		begin
			count_d = count_q + 16'h0001;
			ovf_d   = (count_q == GTC_COUNT_MAX);
		end

	end

	// Configuration registers
	always_comb
	begin
		ctrl_d = hit(req, GTC_OFF_TIMER_CONTROL) ? req.wdata : ctrl_q;
		gsrc_d = gsrc_q;
		if (hit(req, GTC_OFF_GATE_SOURCE))
		begin
			gsrc_d = {6'h00, req.wdata[GTC_BIT_GATE_SOURCE],
				req.wdata[GTC_BIT_COMP_SYNC]};
		end
	end

	// Overflow status and mask; set wins over write-one-to-clear
	always_comb
	begin
		stat_d = stat_q;
		if (hit(req, GTC_OFF_IRQ_STATUS) && req.wdata[GTC_BIT_OVERFLOW])
		begin
			stat_d = 1'b0;
		end
		if (ovf_d)
		begin
			stat_d = 1'b1;
		end
		mask_d = hit(req, GTC_OFF_IRQ_MASK) ? req.wdata[GTC_BIT_OVERFLOW] : mask_q;
	end

	// Read data stand for one cycle only, zero otherwise
	always_comb
	begin
		rdata_d = '0;
		if (req.rd)
		begin
			unique case (req.addr)
				GTC_OFF_TIMER_CONTROL: rdata_d = ctrl_q;
				GTC_OFF_COUNT_LOW:     rdata_d = count_q[7:0];
				GTC_OFF_COUNT_HIGH:    rdata_d = count_q[15:8];
				GTC_OFF_GATE_SOURCE:   rdata_d = gsrc_q;
				GTC_OFF_IRQ_STATUS:    rdata_d = {7'h00, stat_q};
				GTC_OFF_IRQ_MASK:      rdata_d = {7'h00, mask_q};
				default:               rdata_d = '0;
			endcase
		end
	end

	// Low after reset, matching the idle level of the count inputs
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ext_prev_q <= 1'b0;
		end
		else
		begin
			ext_prev_q <= ext_prev_d;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			count_q <= GTC_RST_COUNT;
			pre_q   <= '0;
			ovf_q   <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			pre_q   <= pre_d;
			ovf_q   <= ovf_d;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ctrl_q <= GTC_RST_TIMER_CONTROL;
			gsrc_q <= GTC_RST_GATE_SOURCE;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			gsrc_q <= gsrc_d;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			stat_q <= 1'b0;
			mask_q <= GTC_RST_IRQ_MASK[GTC_BIT_OVERFLOW];
		end
		else
		begin
			stat_q <= stat_d;
			mask_q <= mask_d;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rdata_q <= '0;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata           = rdata_q;
	assign o_lowpower_osc_on = osc_on;
	assign o_overflow_pulse  = ovf_q;
	assign o_irq             = stat_q && mask_q;

endmodule
`default_nettype wire

// ### test/gtc_checker.sv
/* Port assertions for gtc_timer.
   Assumes it is bound to every gtc_timer instance. */
`timescale 1ns/1ps
`default_nettype none
module gtc_checker
	import gtc_pkg::*;
(
	input wire logic       i_ref_clk,
	input wire logic       i_reset_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_internal_oscillator_no_clock_output_pin,
	input wire logic       o_lowpower_osc_on,
	input wire logic       o_overflow_pulse,
	input wire logic       o_irq
);
	logic [7:0] ctl_q;
	logic       msk_q;
	// Shadow copies, so outputs can be tied to what software last wrote
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			ctl_q <= 8'h00;
			msk_q <= 1'b0;
		end
		else if (i_wr && i_addr == GTC_OFF_TIMER_CONTROL)
			ctl_q <= i_wdata;
		else if (i_wr && i_addr == GTC_OFF_IRQ_MASK)
			msk_q <= i_wdata[0];
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_ctl_wr_rd;
		i_wr && i_addr == GTC_OFF_TIMER_CONTROL ##1 i_rd && i_addr == GTC_OFF_TIMER_CONTROL;
	endsequence
	property p_ctl_rb;
		s_ctl_wr_rd |=> o_rdata == $past(i_wdata, 2);
	endproperty
	property p_unmapped;
		i_rd && i_addr[2:1] == 2'h3 |=> o_rdata == 8'h00;
	endproperty
	property p_osc_off;
		!i_internal_oscillator_no_clock_output_pin |-> !o_lowpower_osc_on;
	endproperty
	property p_osc_on;
		i_internal_oscillator_no_clock_output_pin |-> o_lowpower_osc_on == ctl_q[3];
	endproperty
	property p_stop;
		!ctl_q[0] && !$past(ctl_q[0]) |-> !o_overflow_pulse;
	endproperty
	property p_irq;
		o_overflow_pulse && msk_q |-> o_irq;
	endproperty
	property p_pulse;
		o_overflow_pulse |=> !o_overflow_pulse;
	endproperty
	property p_irq_hold;
		o_irq && !i_wr |=> o_irq;
	endproperty
	a_ctl_rb: assert property (p_ctl_rb) else $error("ctrl readback wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_osc_off: assert property (p_osc_off) else $error("osc on in wrong mode");
	a_osc_on: assert property (p_osc_on) else $error("osc enable mismatch");
	a_stop: assert property (p_stop) else $error("overflow while stopped");
	a_irq: assert property (p_irq) else $error("irq missing on overflow");
	a_pulse: assert property (p_pulse) else $error("overflow pulse too long");
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
endmodule
bind gtc_timer gtc_checker i_chk (.i_ref_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr,
	.i_rd, .o_rdata, .i_internal_oscillator_no_clock_output_pin, .o_lowpower_osc_on, .o_overflow_pulse, .o_irq);
`default_nettype wire

// ### test/gtc_partner.sv
/* Far side model: count clock, gate pin, comparator, low-power crystal clock.
   Assumes the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module gtc_partner
(
	output logic o_cnt_clk,
	output logic o_gate_n,
	output logic o_cmp,
	output logic o_lp_clk
);
	initial
	begin
		o_cnt_clk = 1'b0;
		o_gate_n = 1'b1;
		o_cmp = 1'b1;
		o_lp_clk = 1'b0;
	end
	// Edges slow and off-grid, so the filter sees each level settle
	task automatic pulse(input int n, input logic lp);
		repeat (n)
		begin
			#47 set_clk(lp, 1'b1);
			#47 set_clk(lp, 1'b0);
		end
	endtask
	task automatic set_clk(input logic lp, input logic v);
		if (lp)
			o_lp_clk = v;
		else
			o_cnt_clk = v;
	endtask
	task automatic set_gate(input logic g, input logic c);
		o_gate_n <= g;
		o_cmp <= c;
	endtask
endmodule
`default_nettype wire

// ### test/gtc_timer_tb_top.sv
/* Self-checking bench for gtc_timer.
   Assumes gtc_partner drives the pins. */
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_tb_top
	import gtc_pkg::*;
	;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       tk = 1'b0;
	logic       internal_oscillator = 1'b0;
	logic [7:0] rdata;
	logic       osc_on, ovf, irq;
	wire        ext, gate_n, cmp, lp;
	int         n_errors = 0;
	int         checked = 0;
	int         cyc = 0;
	always #5 clk = ~clk;
	gtc_partner i_partner (.o_cnt_clk(ext), .o_gate_n(gate_n), .o_cmp(cmp), .o_lp_clk(lp));
	gtc_timer i_dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_instr_tick(tk),
		.i_internal_oscillator_no_clock_output_pin(internal_oscillator), .i_external_count_pin(ext), .i_lowpower_osc_clk(lp),
		.i_gate_pin_n(gate_n), .i_second_comparator_output(cmp),
		.o_lowpower_osc_on(osc_on), .o_overflow_pulse(ovf), .o_irq(irq));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, s, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		if (wr)
			@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rc(input logic [2:0] a, input logic [7:0] e, input string s);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e, s);
		@(posedge clk);
	endtask
	task automatic tick(input int n);
		repeat (n)
		begin
			tk <= 1'b1;
			@(posedge clk);
			tk <= 1'b0;
			@(posedge clk);
		end
	endtask
	task automatic clr();
		wr_reg(GTC_OFF_COUNT_LOW, 8'h00);
		wr_reg(GTC_OFF_COUNT_HIGH, 8'h00);
	endtask
	task automatic t_reset();
		rc(GTC_OFF_TIMER_CONTROL, GTC_RST_TIMER_CONTROL, "ctrl reset");
		rc(GTC_OFF_GATE_SOURCE, GTC_RST_GATE_SOURCE, "gate src reset");
		rc(GTC_OFF_IRQ_MASK, GTC_RST_IRQ_MASK, "mask reset");
		wr_reg(3'h7, 8'hff);
		rc(3'h7, 8'h00, "unmapped");
		$display("reset test done");
	endtask
	task automatic t_run();
		clr();
		wr_reg(GTC_OFF_TIMER_CONTROL, 8'h01);
		rc(GTC_OFF_TIMER_CONTROL, 8'h01, "ctrl readback");
		tick(5);
		rc(GTC_OFF_COUNT_LOW, 8'h05, "running");
		wr_reg(GTC_OFF_TIMER_CONTROL, 8'h00);
		tick(5);
		rc(GTC_OFF_COUNT_LOW, 8'h05, "stopped");
		for (int p = 0; p < 4; p++)
		begin
			clr();
			wr_reg(GTC_OFF_TIMER_CONTROL, {2'h0, 2'(p), 4'h1});
			tick(8);
			rc(GTC_OFF_COUNT_LOW, 8'(8 >> p), "prescale");
		end
		$display("run test done");
	endtask
	task automatic t_gate();
		// Source, control, pin and comparator levels, expected count
		logic [19:0] t[8] = '{20'h2_4010, 20'h2_4130, 20'h2_4114, 20'h2_C110,
			20'h2_C134, 20'h2_0134, 20'h0_4110, 20'h0_C114};
		foreach (t[i])
		begin
			clr();
			wr_reg(GTC_OFF_GATE_SOURCE, {4'h0, t[i][19:16]});
			i_partner.set_gate(t[i][5], t[i][4]);
			repeat (6) @(posedge clk);
			wr_reg(GTC_OFF_TIMER_CONTROL, t[i][15:8]);
			tick(4);
			rc(GTC_OFF_COUNT_LOW, {4'h0, t[i][3:0]}, "gate");
		end
		$display("gate test done");
	endtask
	task automatic t_ext();
		for (int a = 0; a < 2; a++)
		begin
			clr();
			wr_reg(GTC_OFF_TIMER_CONTROL, {5'h00, 1'(a), 2'h3});
			i_partner.pulse(3, 1'b0);
			repeat (8) @(posedge clk);
			rc(GTC_OFF_COUNT_LOW, 8'h03, "ext count");
		end
		internal_oscillator <= 1'b1;
		clr();
		wr_reg(GTC_OFF_TIMER_CONTROL, 8'h0b);
		#1 chk(osc_on, 8'h01, "osc on");
		i_partner.pulse(3, 1'b1);
		repeat (8) @(posedge clk);
		rc(GTC_OFF_COUNT_LOW, 8'h03, "osc count");
		internal_oscillator <= 1'b0;
		clr();
		#1 chk(osc_on, 8'h00, "osc ignored");
		i_partner.pulse(3, 1'b1);
		repeat (8) @(posedge clk);
		rc(GTC_OFF_COUNT_LOW, 8'h00, "osc count ignored");
		internal_oscillator <= 1'b1;
		wr_reg(GTC_OFF_TIMER_CONTROL, 8'h00);
		#1 chk(osc_on, 8'h00, "osc off");
		@(posedge clk);
		internal_oscillator <= 1'b0;
		$display("ext test done");
	endtask
	task automatic t_irq();
		wr_reg(GTC_OFF_IRQ_MASK, 8'h01);
		wr_reg(GTC_OFF_COUNT_LOW, 8'hff);
		wr_reg(GTC_OFF_COUNT_HIGH, 8'hff);
		wr_reg(GTC_OFF_TIMER_CONTROL, 8'h01);
		tk <= 1'b1;
		@(posedge clk);
		tk <= 1'b0;
		#1 chk(ovf, 8'h01, "overflow pulse");
		chk(irq, 8'h01, "irq");
		@(posedge clk);
		#1 chk(ovf, 8'h00, "pulse one cycle");
		@(posedge clk);
		rc(GTC_OFF_COUNT_HIGH, 8'h00, "wrap");
		rc(GTC_OFF_IRQ_STATUS, 8'h01, "status");
		wr_reg(GTC_OFF_IRQ_MASK, 8'h00);
		#1 chk(irq, 8'h00, "irq masked");
		@(posedge clk);
		wr_reg(GTC_OFF_IRQ_MASK, 8'h01);
		wr_reg(GTC_OFF_IRQ_STATUS, 8'h01);
		@(posedge clk);
		#1 chk(irq, 8'h00, "irq clear");
		$display("irq test done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_errors++;
			$display("[FAIL] %0t timeout", $time);
			complete_run();
		end
	end
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_run();
		t_gate();
		t_ext();
		t_irq();
		complete_run();
	end
endmodule
`default_nettype wire
